//--- common/bdtp_consts.svh
`ifndef BDTP_CONSTS_SVH
`define BDTP_CONSTS_SVH

// ==========================================================================
// Field values and sizes
`define BDTP_PST_HALT      4'hF
`define BDTP_PST_START_C   4'hC
`define BDTP_PST_START_D   4'hD
`define BDTP_PACKET_BITS   6'h11
`define BDTP_SYNC_STAGES   2
`define BDTP_SO_IDLE       1'b0
`define BDTP_DDATA_MANUAL_BREAKPOINT_IN    4'h8
`define BDTP_STATUS_DLY_NS 50
`define BDTP_CLK_PERIOD_NS 100

`endif

//--- common/bdtp_pkg.sv
// ==========================================================================
// Types shared by the debug and trace port
package bdtp_pkg;
    // Trace bundle from the core
    typedef struct packed {
        logic [3:0] status;
        logic [3:0] data;
        logic       valid;
    } bdtp_trace_s;

    // One serial packet word
    typedef logic [16:0] bdtp_word_t;

    typedef enum logic [1:0] {
        BDTP_RUN,
        BDTP_WAIT_END,
        BDTP_HALTED
    } bdtp_core_e;
endpackage : bdtp_pkg

//--- core/bdtp_buf2.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Two-entry buffer, read data muxed combinationally from storage
module bdtp_buf2 (
    input  wire logic          ref_clk,
    input  wire logic          rst_n,
    input  wire logic [16:0]   in_data,
    input  wire logic          in_valid,
    output logic               in_ready,
    output logic [16:0]        out_data,
    output logic               out_valid,
    input  wire logic          out_ready
);
    logic [16:0] mem [0:1];
    logic        wr_ptr;
    logic        rd_ptr;
    logic [1:0]  count;
    wire         push = in_valid && in_ready;
    wire         pop  = out_valid && out_ready;

    // Ready is honest: low only when both entries hold data
    assign in_ready  = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data  = mem[rd_ptr];

    // Storage
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers and fill level
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule : bdtp_buf2
`default_nettype wire

//--- core/bdtp_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "bdtp_consts.svh"
// ==========================================================================
// Background debug serial port and real-time trace outputs
module bdtp_port (
    input  wire logic                 ref_clk,
    input  wire logic                 rst_n,
    // Serial link pins
    input  wire logic                 debug_serial_clock,
    input  wire logic                 debug_serial_in,
    output logic                      debug_serial_out,
    // Manual breakpoint pin, active low
    input  wire logic                 manual_breakpoint_in_n,
    // Control bits
    input  wire logic                 breakpoint_disable,
    input  wire logic                 status_clock_disable,
    // Core side
    input  wire bdtp_pkg::bdtp_trace_s core_trace,
    input  wire logic                 core_instr_done,
    input  wire logic                 core_resume,
    input  wire logic                 core_in_reset,
    output logic                      core_halt,
    output logic                      core_debug_irq,
    // Received packets toward the debug module, reply words from it
    output logic [16:0]               rx_word,
    output logic                      rx_valid,
    input  wire logic                 rx_ready,
    input  wire logic [16:0]          tx_word,
    input  wire logic                 tx_load,
    // Trace pins
    output logic [3:0]                processor_status_out,
    output logic [3:0]                debug_data_out,
    output logic                      status_clock_out,
    output logic                      all_status_and_out
);
    import bdtp_pkg::*;

    // ======================================================================
    // Input synchronisers
    logic [1:0] sclk_sync;
    logic [1:0] sin_sync;
    logic [1:0] manual_breakpoint_in_sync;

    always_ff @(posedge ref_clk) begin
        sclk_sync <= {sclk_sync[0], debug_serial_clock};
        sin_sync  <= {sin_sync[0], debug_serial_in};
        manual_breakpoint_in_sync <= {manual_breakpoint_in_sync[0], manual_breakpoint_in_n};
    end

    // ======================================================================
    // Serial clock validation
    logic sclk_prev;
    logic sclk_level;
    wire  sclk_agree = (sclk_sync[1] == sclk_prev);
    wire  sclk_rise  = sclk_agree && sclk_prev && !sclk_level;

    // Level taken only when two consecutive samples agree
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sclk_prev  <= 1'b0;
            sclk_level <= 1'b0;
        end else begin
            sclk_prev <= sclk_sync[1];
            if (sclk_agree) begin
                sclk_level <= sclk_prev;
            end
        end
    end

    // ======================================================================
    // Serial shifter
    logic [16:0] shift_in;
    logic [16:0] shift_out;
    logic [5:0]  bit_cnt;
    logic        buf_in_ready;
    wire         word_done = sclk_rise && (bit_cnt == `BDTP_PACKET_BITS - 6'h1);
    wire [16:0]  next_shift_in = {shift_in[15:0], sin_sync[1]};

    // Sample on the accepted rising edge; no stall, shifting goes on when the buffer is full
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            shift_in  <= 17'h00000;
            shift_out <= 17'h00000;
            bit_cnt   <= 6'h00;
        end else if (sclk_rise) begin
            shift_in  <= next_shift_in;
            shift_out <= {shift_out[15:0], 1'b0};
            bit_cnt   <= word_done ? 6'h00 : bit_cnt + 6'h01;
        end else if (tx_load && bit_cnt == 6'h00) begin
            shift_out <= tx_word;
        end
    end

    // Output bit registered at the edge that accepts the high level.
    // The bit is taken before the shift, so the first reply bit is
    // the top bit of the loaded word and no bit is skipped.
    // Waiting any longer would let the change slip past the point
    // where the probe has already dropped its clock again.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            debug_serial_out <= `BDTP_SO_IDLE;
        end else if (sclk_rise) begin
            debug_serial_out <= shift_out[16];
        end
    end

    // Word handoff; a word finishing while full is dropped by the buffer's ready
    wire buf_push = word_done && buf_in_ready;

    bdtp_buf2 u_buf (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .in_data   (next_shift_in),
        .in_valid  (buf_push),
        .in_ready  (buf_in_ready),
        .out_data  (rx_word),
        .out_valid (rx_valid),
        .out_ready (rx_ready)
    );

    // ======================================================================
    // Breakpoint handling
    logic       manual_breakpoint_in_prev;
    bdtp_core_e core_state;
    wire        manual_breakpoint_in_edge = !manual_breakpoint_in_sync[1] && manual_breakpoint_in_prev;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            manual_breakpoint_in_prev      <= 1'b1;
            core_state     <= BDTP_RUN;
            core_halt      <= 1'b0;
            core_debug_irq <= 1'b0;
        end else begin
            manual_breakpoint_in_prev      <= manual_breakpoint_in_sync[1];
            core_debug_irq <= manual_breakpoint_in_edge && breakpoint_disable;
            case (core_state)
                BDTP_RUN: begin
                    if (manual_breakpoint_in_edge && !breakpoint_disable) begin
                        core_state <= BDTP_WAIT_END;
                    end
                end
                BDTP_WAIT_END: begin
                    if (core_instr_done) begin
                        core_state <= BDTP_HALTED;
                        core_halt  <= 1'b1;
                    end
                end
                BDTP_HALTED: begin
                    if (core_resume) begin
                        core_state <= BDTP_RUN;
                        core_halt  <= 1'b0;
                    end
                end
                default: begin
                    core_state <= BDTP_RUN;
                end
            endcase
        end
    end

    // ======================================================================
    // Trace outputs
    logic       pst_started;
    logic       manual_breakpoint_in_flag;
    wire [3:0]  next_status = core_halt ? `BDTP_PST_HALT : core_trace.status;
    wire        start_code  = (next_status == `BDTP_PST_START_C) ||
                              (next_status == `BDTP_PST_START_D) ||
                              (next_status == `BDTP_PST_HALT);
    wire        trace_quiet = status_clock_disable || !pst_started;
    wire [3:0]  next_data   = core_trace.valid ? core_trace.data :
                              (manual_breakpoint_in_flag ? `BDTP_DDATA_MANUAL_BREAKPOINT_IN : 4'h0);

    // Status clock held until a start code during reset processing
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pst_started <= 1'b0;
        end else if (core_in_reset && start_code) begin
            pst_started <= 1'b1;
        end else if (!core_in_reset && !pst_started) begin
            pst_started <= 1'b1;
        end
    end

    // Breakpoint status flag shown on the data lines
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            manual_breakpoint_in_flag <= 1'b0;
        end else if (manual_breakpoint_in_edge) begin
            manual_breakpoint_in_flag <= 1'b1;
        end else if (!core_trace.valid && !trace_quiet) begin
            manual_breakpoint_in_flag <= 1'b0;
        end
    end

    // Status and data update on the core clock, frozen while quiet
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            processor_status_out <= 4'h0;
            debug_data_out       <= 4'h0;
            all_status_and_out   <= 1'b0;
        end else if (!trace_quiet) begin
            processor_status_out <= next_status;
            debug_data_out       <= next_data;
            all_status_and_out   <= &next_status;
        end else begin
            processor_status_out <= processor_status_out;
            debug_data_out       <= debug_data_out;
            all_status_and_out   <= &processor_status_out;
        end
    end

    // Status clock: negedge toggle at half the core clock rate, rising mid window.
    // Limitation: a half-period delay is the only one a single clock gives.
    logic status_clk_en;
    always_ff @(negedge ref_clk) begin
        if (!rst_n) begin
            status_clk_en <= 1'b0;
        end else begin
            status_clk_en <= !trace_quiet;
        end
    end


    // Rising edge placed half a period into a valid window.
    // The status outputs change on the rising core edge, so a rise
    // on the falling core edge lands in the middle of their window.
    // Trade-off: one flop on one edge only toggles, so the pin runs
    // at half the core rate; the probe still sees every rise centred.
    // Once the enable drops the pin is parked low and no further rising edge reaches the probe.
    always_ff @(negedge ref_clk) begin
        if (!rst_n) begin
            status_clock_out <= 1'b0;
        end else begin
            status_clock_out <= status_clk_en && !status_clock_out;
        end
    end

    // Debug data and status observable to the probe via the delayed clock.
    // Hazard: the enable is itself a falling-edge flop, so stopping
    // takes effect one falling edge late; the trace pins are already
    // frozen by then, so the probe never samples a moving value.
endmodule : bdtp_port
`default_nettype wire

//--- dv/bdtp_port_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Port checks for the debug port
module bdtp_port_checker (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        debug_serial_clock,
    input wire logic        debug_serial_out,
    input wire logic        breakpoint_disable,
    input wire logic        status_clock_disable,
    input wire logic        core_halt,
    input wire logic        core_debug_irq,
    input wire logic [16:0] rx_word,
    input wire logic        rx_valid,
    input wire logic        rx_ready,
    input wire logic [3:0]  processor_status_out,
    input wire logic [3:0]  debug_data_out,
    input wire logic        all_status_and_out
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // Serial side: the pin must have been seen high before the output moves
    a_so_after_clk: assert property ($changed(debug_serial_out)
        |-> $past(debug_serial_clock, 2) && $past(debug_serial_clock, 3))
        else $error("serial output moved without a settled high serial clock");
    a_so_reset_idle: assert property (disable iff (1'b0) !rst_n && $past(!rst_n)
        |-> !debug_serial_out && !rx_valid)
        else $error("serial logic not idle under reset");
    a_rx_word_holds: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_word))
        else $error("received word dropped while stalled");
    // Halt and interrupt paths
    a_halt_shows_f: assert property (core_halt && $past(core_halt)
        |-> processor_status_out == 4'hF)
        else $error("halted core without status F");
    a_halt_needs_en: assert property ($rose(core_halt) |-> !breakpoint_disable)
        else $error("halt while breakpoint disable set");
    a_irq_one_cycle: assert property (core_debug_irq |=> !core_debug_irq)
        else $error("debug interrupt longer than one cycle");
    a_irq_needs_dis: assert property (core_debug_irq |-> breakpoint_disable && !core_halt)
        else $error("debug interrupt without breakpoint disable");
    // Trace outputs
    a_and_of_status: assert property (all_status_and_out == &processor_status_out)
        else $error("all-status output differs from AND of status");
    a_quiet_trace: assert property (status_clock_disable && $past(status_clock_disable)
        |-> $stable(processor_status_out) && $stable(debug_data_out))
        else $error("trace outputs toggled while quiet");

    c_halt: cover property ($rose(core_halt));
    c_irq: cover property (core_debug_irq);
    c_pop: cover property (rx_valid && rx_ready);
endmodule : bdtp_port_checker

bind bdtp_port bdtp_port_checker u_chk (
    .ref_clk, .rst_n, .debug_serial_clock, .debug_serial_out, .breakpoint_disable,
    .status_clock_disable, .core_halt, .core_debug_irq, .rx_word, .rx_valid, .rx_ready,
    .processor_status_out, .debug_data_out, .all_status_and_out
);
`default_nettype wire

//--- dv/bdtp_probe.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Debug probe: 800 ns serial clock, still between frames
module bdtp_probe (
    output logic      sclk,
    output logic      sdi,
    input  wire logic sdo
);
    initial begin
        sclk = 1'b0;
        sdi = 1'b0;
    end

    // MSB first; reply read late in low phase, output lags the accepted rise
    task automatic xfer(input logic [16:0] w, output logic [16:0] r);
        #37;
        for (int i = 16; i >= 0; i--) begin
            sdi = w[i];
            #100 sclk = 1'b1;
            #400 sclk = 1'b0;
            #250 r[i] = sdo;
            #50;
        end
        sdi = ~sdi; // Inverted line, not released: no stale level
    endtask : xfer
endmodule : bdtp_probe
`default_nettype wire

//--- dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Debug port testbench
module tb;
    import bdtp_pkg::*;
    logic        ref_clk, rst_n, debug_serial_clock, debug_serial_in, debug_serial_out;
    logic        manual_breakpoint_in_n, breakpoint_disable, status_clock_disable;
    bdtp_trace_s core_trace;
    logic        core_instr_done, core_resume, core_in_reset, core_halt, core_debug_irq;
    logic [16:0] rx_word, tx_word, got;
    logic        rx_valid, rx_ready, tx_load, status_clock_out, all_status_and_out;
    logic [3:0]  processor_status_out, debug_data_out;
    int          n_mismatch, n_tests;

    bdtp_port DUT (.ref_clk, .rst_n, .debug_serial_clock, .debug_serial_in, .debug_serial_out,
        .manual_breakpoint_in_n, .breakpoint_disable, .status_clock_disable, .core_trace,
        .core_instr_done, .core_resume, .core_in_reset, .core_halt, .core_debug_irq, .rx_word,
        .rx_valid, .rx_ready, .tx_word, .tx_load, .processor_status_out, .debug_data_out,
        .status_clock_out, .all_status_and_out);
    bdtp_probe P (.sclk(debug_serial_clock), .sdi(debug_serial_in), .sdo(debug_serial_out));

    always #50 ref_clk = ~ref_clk;

    // ======================================================================
    // Helpers
    task automatic chk(input string nm, input logic [16:0] e, input logic [16:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cyc

    task automatic pop(input logic [16:0] e);
        chk("rx_valid", 17'h1, rx_valid);
        chk("rx_word", e, rx_word);
        rx_ready = 1'b1;
        cyc(1);
        rx_ready = 1'b0;
        cyc(1);
    endtask : pop

    task automatic tally_and_finish;
        $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish

    // ======================================================================
    // Scenarios
    task automatic t_serial;
        tx_word = 17'h0F0F1;
        tx_load = 1'b1;
        cyc(1);
        tx_load = 1'b0;
        P.xfer(17'h1A5C3, got);
        cyc(2);
        chk("reply", 17'h0F0F1, got);
        pop(17'h1A5C3);
        chk("rx_valid", 17'h0, rx_valid);
    endtask : t_serial

    // Receiver stalls: third word finds the buffer full and is lost
    task automatic t_stall;
        P.xfer(17'h00001, got);
        P.xfer(17'h1FFFE, got);
        P.xfer(17'h15555, got);
        cyc(2);
        pop(17'h00001);
        pop(17'h1FFFE);
        chk("rx_valid", 17'h0, rx_valid);
    endtask : t_stall

    task automatic t_break;
        core_trace = '{status: 4'h1, data: 4'h0, valid: 1'b1};
        manual_breakpoint_in_n = 1'b0;
        cyc(8);
        chk("core_halt", 17'h0, core_halt);
        chk("all_status", 17'h0, all_status_and_out);
        core_instr_done = 1'b1;
        cyc(1);
        core_instr_done = 1'b0;
        for (int k = 0; k < 20 && core_halt !== 1'b1; k++) cyc(1);
        cyc(2);
        chk("core_halt", 17'h1, core_halt);
        chk("status", 17'hF, processor_status_out);
        chk("all_status", 17'h1, all_status_and_out);
        manual_breakpoint_in_n = 1'b1;
        core_resume = 1'b1;
        cyc(1);
        core_resume = 1'b0;
        cyc(4);
        chk("core_halt", 17'h0, core_halt);
        chk("status", 17'h1, processor_status_out);
    endtask : t_break

    task automatic t_break_irq;
        logic seen;
        seen = 1'b0;
        breakpoint_disable = 1'b1;
        cyc(1);
        manual_breakpoint_in_n = 1'b0;
        for (int k = 0; k < 12; k++) begin
            core_instr_done = (k == 3);
            cyc(1);
            if (core_debug_irq === 1'b1) seen = 1'b1;
        end
        chk("irq_seen", 17'h1, seen);
        chk("core_halt", 17'h0, core_halt);
        manual_breakpoint_in_n = 1'b1;
        cyc(2);
        breakpoint_disable = 1'b0;
    endtask : t_break_irq

    task automatic t_trace;
        logic sc;
        core_trace = '{status: 4'h5, data: 4'hA, valid: 1'b1};
        cyc(4);
        chk("status", 17'h5, processor_status_out);
        chk("ddata", 17'hA, debug_data_out);
        @(posedge ref_clk) sc = status_clock_out;
        @(posedge ref_clk) chk("status_clock", {16'h0, ~sc}, status_clock_out);
        cyc(1);
        status_clock_disable = 1'b1;
        cyc(2);
        core_trace = '{status: 4'h3, data: 4'h6, valid: 1'b1};
        cyc(4);
        chk("status", 17'h5, processor_status_out);
        chk("ddata", 17'hA, debug_data_out);
        chk("status_clock", 17'h0, status_clock_out);
        status_clock_disable = 1'b0;
        cyc(4);
        chk("status", 17'h3, processor_status_out);
        chk("ddata", 17'h6, debug_data_out);
    endtask : t_trace

    // Mid-run reset with the core in reset processing: clock held until C
    task automatic t_reset_start;
        rst_n = 1'b0;
        core_in_reset = 1'b1;
        core_trace = '{status: 4'h1, data: 4'h0, valid: 1'b1};
        cyc(3);
        rst_n = 1'b1;
        cyc(4);
        chk("status", 17'h0, processor_status_out);
        chk("status_clock", 17'h0, status_clock_out);
        chk("debug_serial_out", 17'h0, debug_serial_out);
        core_trace = '{status: 4'hC, data: 4'h0, valid: 1'b1};
        cyc(4);
        chk("status", 17'hC, processor_status_out);
        core_in_reset = 1'b0;
        cyc(2);
    endtask : t_reset_start

    // ======================================================================
    // Main sequence and watchdog
    initial begin
        ref_clk = 1'b0;
        rst_n = 1'b0;
        manual_breakpoint_in_n = 1'b1;
        breakpoint_disable = 1'b0;
        status_clock_disable = 1'b0;
        core_trace = '0;
        core_instr_done = 1'b0;
        core_resume = 1'b0;
        core_in_reset = 1'b0;
        rx_ready = 1'b0;
        tx_word = '0;
        tx_load = 1'b0;
        n_mismatch = 0;
        n_tests = 0;
        cyc(10);
        rst_n = 1'b1;
        cyc(3);
        chk("debug_serial_out", 17'h0, debug_serial_out);
        t_serial();
        t_stall();
        t_break();
        t_break_irq();
        t_trace();
        t_reset_start();
        tally_and_finish();
    end

    // Scenarios need well under 100 us; ten times that means a hang
    initial begin
        #1_000_000;
        n_mismatch++;
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
